/* File: shared/fsc_pkg.sv */
package fsc_pkg;
  // Word offsets on the register bus
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_THR  = 8'h04;
  localparam logic [7:0] A_TIME = 8'h08;
  localparam logic [7:0] A_SEND = 8'h0c;
  localparam logic [7:0] A_HGT  = 8'h10;
  localparam logic [7:0] A_STAT = 8'h14;
  localparam logic [1:0] A_FAC_HI = 2'h1;  // 0x40..0x7f, 8 bytes each
  // Reset values
  localparam logic [3:0]  R_NFAC  = 4'h4;
  localparam logic [5:0]  R_KLUX  = 6'h0a;
  localparam logic [4:0]  R_HYST  = 5'h03;
  localparam logic [13:0] R_HGT   = 14'h00fa;
  localparam logic [7:0]  R_OPEN  = 8'h96;
  localparam logic [6:0]  R_SMIN  = 7'h32;
  // Scales and counts
  localparam logic [17:0] LUX_PER_KLUX = 18'h003e8;
  localparam logic [5:0]  SEC_PER_MIN  = 6'h3c;
  localparam logic [5:0]  CYC_STEP_MIN = 6'h05;
  localparam logic [11:0] SUN_SEC_MULT = 12'h00a;
  localparam logic [3:0]  MAX_WAIT_MIN = 4'ha;
  localparam logic [6:0]  PCT_FULL     = 7'h64;
  localparam logic [8:0]  DEG_HALF     = 9'h0b4;
  localparam logic [8:0]  DEG_FULL     = 9'h168;
  // Brightness decision, Gray along OFF->WAIT->ON->WAIT
  typedef enum logic [1:0] {
    ST_OFF = 2'b00, ST_ONW = 2'b01, ST_ON = 2'b11, ST_OFFW = 2'b10
  } fsc_bst_type;
  // Telegram kinds on the transmit port
  typedef enum logic [1:0] {
    K_SHADE = 2'h0, K_HGT = 2'h1, K_SLAT = 2'h2, K_SUN = 2'h3
  } fsc_kind_type;
endpackage : fsc_pkg

/* File: rtl/fsc_ctrl.sv */
// The Wishbone register port and the register offsets were decided locally.
`timescale 1ns/1ps
// Contract
// - Keep mounting height, 0-8848 m, default 250; the 14-bit hgt field takes 0-16383, unchecked
// - Threshold from internal constant or bus value
// - Internal threshold 3-50 klux, times 1000; the 6-bit klux field takes 0-63, unchecked
// - Active above threshold, off below minus hysteresis
// - Optional shading resend every 5-40 minutes; the 4-bit cyc code 1-12 gives 5-60 minutes, unchecked; 13-15 never fire, the minute count wraps at 64
// - Switch-on only after selectable delay
// - Switch-off only after selectable delay
// - Shading output as bit or byte
// - Wait 0-10 minutes before slat send
// - Sun position resent every value times 10 s
// - Sun position resent on elevation step
// - Slat position resent every N minutes
// - Slat resent on 1-15 degree elevation step
// - Height at shading end only if enabled
// - Slat at shading end only if enabled
// - One to eight independent facades, default four; the 4-bit nfac field takes 0-15, unchecked
// - Facade orientation 0-360 degrees, 0 north; the 9-bit ori field takes 0-511, unchecked
// - Opening angle internal or from bus byte
// - Sunlit only inside opening angle; zero never
// - Slat min and max percentages per facade
// - Offset percent added to tracked slat position
// - Blind output bit or byte height
// - No valid time forces shading to zero
module fsc_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        tick_i,
  input  wire logic        time_valid_i,
  input  wire logic [17:0] lux_i,
  input  wire logic [6:0]  elev_i,
  input  wire logic [8:0]  azim_i,
  output logic             tx_valid_o,
  output logic [1:0]       tx_kind_o,
  output logic [2:0]       tx_fac_o,
  output logic [15:0]      tx_data_o
);
  // Whole module state
  typedef struct packed {
    logic            ack;
    logic [31:0]     rd;
    logic            ext, fmtb, hend, send; // CTRL bits
    logic [3:0]      nfac;
    logic [5:0]      klux;
    logic [4:0]      hyst;
    logic [7:0]      eklux;  // Bus-received threshold
    logic [2:0]      on_sel, off_sel;
    logic [3:0]      cyc, wmin;
    logic [7:0]      sun_cyc, slat_cyc;
    logic            sun15;
    logic [2:0]      slat_step;
    logic [13:0]     hgt;
    logic [7:0][8:0] ori;
    logic [7:0]      oext, bbyte;
    logic [7:0][7:0] oint, obus;
    logic [7:0][6:0] hv, smin, smax, offs;
    fsc_pkg::fsc_bst_type bst;
    logic [11:0]     btmr;
    logic [5:0]      sec, cmin;
    logic [7:0]      smcnt;
    logic [11:0]     suncnt;
    logic [7:0]      shd, wrun, p_shd, p_hgt, p_slat;
    logic [7:0][9:0] wcnt;
    logic            p_sun;
    logic [6:0]      el_sun, el_slat;
    logic            txv;
    logic [1:0]      kind;
    logic [2:0]      fac;
    logic [15:0]     txd;
  } fsc_st_type;

  fsc_st_type s_q, s_d;

  // Delay code to seconds: none,1,3,5,10,15,30,60 min
  function automatic logic [11:0] dly_sec(input logic [2:0] c);
    case (c)
      3'h1:    dly_sec = 12'h03c;
      3'h2:    dly_sec = 12'h0b4;
      3'h3:    dly_sec = 12'h12c;
      3'h4:    dly_sec = 12'h258;
      3'h5:    dly_sec = 12'h384;
      3'h6:    dly_sec = 12'h708;
      3'h7:    dly_sec = 12'he10;
      default: dly_sec = 12'h000;
    endcase
  endfunction : dly_sec

  // Absolute elevation difference
  function automatic logic [6:0] el_diff(input logic [6:0] a, input logic [6:0] b);
    el_diff = (a >= b) ? a - b : b - a;
  endfunction : el_diff

  // Register word image at an address
  function automatic logic [31:0] reg_rd(input fsc_st_type s, input logic [7:0] a);
    logic [2:0] f;
    f = a[5:3];
    reg_rd = 32'h0;
    if (a[7:6] == fsc_pkg::A_FAC_HI) begin
      if (!a[2]) reg_rd = {1'b0, s.hv[f], s.oint[f], 5'h0, s.bbyte[f], s.oext[f], s.ori[f]};
      else       reg_rd = {s.obus[f], 1'b0, s.offs[f], 1'b0, s.smax[f], 1'b0, s.smin[f]};
    end else begin
      case ({a[7:2], 2'b00})
        fsc_pkg::A_CTRL: reg_rd = {24'h0, s.nfac, s.send, s.hend, s.fmtb, s.ext};
        fsc_pkg::A_THR:  reg_rd = {8'h0, s.eklux, 3'h0, s.hyst, 2'h0, s.klux};
        fsc_pkg::A_TIME: reg_rd = {16'h0, s.wmin, s.cyc, 1'b0, s.off_sel, 1'b0, s.on_sel};
        fsc_pkg::A_SEND: reg_rd = {5'h0, s.slat_step, s.slat_cyc, 7'h0, s.sun15, s.sun_cyc};
        fsc_pkg::A_HGT:  reg_rd = {18'h0, s.hgt};
        fsc_pkg::A_STAT: reg_rd = {14'h0, s.bst, s.p_shd, s.shd};
        default:         reg_rd = 32'h0;
      endcase
    end
  endfunction : reg_rd

  // Threshold and release level in lux
  logic [17:0] thr, hys, rel;
  logic        above, below, active;
  always_comb begin
    thr = s_q.ext ? 18'(s_q.eklux) * fsc_pkg::LUX_PER_KLUX
                  : 18'(s_q.klux) * fsc_pkg::LUX_PER_KLUX;
    hys = 18'(s_q.hyst) * fsc_pkg::LUX_PER_KLUX;
    rel = (thr > hys) ? thr - hys : 18'h0;
    above = lux_i > thr;
    below = lux_i < rel;
    active = (s_q.bst == fsc_pkg::ST_ON) || (s_q.bst == fsc_pkg::ST_OFFW);
  end

  // Per facade sun check, shortest way round the circle
  logic [7:0] sunlit, open0, want;
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_fac
      logic [8:0] dd, d2;
      logic [7:0] op;
      always_comb begin
        op = s_q.oext[g] ? s_q.obus[g] : s_q.oint[g];
        dd = (azim_i >= s_q.ori[g]) ? azim_i - s_q.ori[g] : s_q.ori[g] - azim_i;
        d2 = (dd > fsc_pkg::DEG_HALF) ? fsc_pkg::DEG_FULL - dd : dd;
        open0[g] = (op == 8'h00);
        // Twice the distance against the full opening: half the angle each side
        sunlit[g] = !open0[g] && ({d2, 1'b0} <= {2'b00, op});
        want[g] = active && sunlit[g] && time_valid_i
                  && (4'(g) < s_q.nfac);
      end
    end
  endgenerate

  // Next state
  logic [31:0] wmask, wv;
  logic [6:0]  stp;
  logic [7:0]  tr;     // Headroom: 100 minus elevation plus offset reaches 227
  logic [2:0]  f;
  logic        mtick, done;
  always_comb begin
    s_d = s_q;
    f = wb_adr_i[5:3];
    wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wv = (reg_rd(s_q, wb_adr_i) & ~wmask) | (wb_dat_i & wmask);
    stp = 7'h0;
    tr = 8'h0;
    done = 1'b0;
    // Bus slave: one wait state, ack for one cycle
    s_d.ack = wb_cyc_i && wb_stb_i && !s_q.ack;
    s_d.rd = reg_rd(s_q, wb_adr_i);
    if (s_d.ack && wb_we_i) begin
      if (wb_adr_i[7:6] == fsc_pkg::A_FAC_HI) begin
        if (!wb_adr_i[2]) begin
          s_d.ori[f] = wv[8:0];
          s_d.oext[f] = wv[9];
          s_d.bbyte[f] = wv[10];
          s_d.oint[f] = wv[23:16];
          s_d.hv[f] = wv[30:24];
        end else begin
          s_d.smin[f] = wv[6:0];
          s_d.smax[f] = wv[14:8];
          s_d.offs[f] = wv[22:16];
          s_d.obus[f] = wv[31:24];
        end
      end else begin
        case ({wb_adr_i[7:2], 2'b00})
          fsc_pkg::A_CTRL: begin
            {s_d.nfac, s_d.send, s_d.hend, s_d.fmtb, s_d.ext} = wv[7:0];
          end
          fsc_pkg::A_THR: begin
            s_d.klux = wv[5:0];
            s_d.hyst = wv[12:8];
            s_d.eklux = wv[23:16];
          end
          fsc_pkg::A_TIME: begin
            s_d.on_sel = wv[2:0];
            s_d.off_sel = wv[6:4];
            s_d.cyc = wv[11:8];
            s_d.wmin = (wv[15:12] > fsc_pkg::MAX_WAIT_MIN) ? fsc_pkg::MAX_WAIT_MIN : wv[15:12];
          end
          fsc_pkg::A_SEND: begin
            s_d.sun_cyc = wv[7:0];
            s_d.sun15 = wv[8];
            s_d.slat_cyc = wv[23:16];
            s_d.slat_step = wv[26:24];
          end
          fsc_pkg::A_HGT: s_d.hgt = wv[13:0];
          default: s_d.hgt = s_q.hgt;
        endcase
      end
    end
    // Minute divider on the one second tick
    mtick = tick_i && (s_q.sec == fsc_pkg::SEC_PER_MIN - 6'h1);
    if (tick_i) s_d.sec = mtick ? 6'h0 : s_q.sec + 6'h1;
    // Brightness decision with delays
    case (s_q.bst)
      fsc_pkg::ST_OFF: begin
        s_d.btmr = 12'h0;
        if (above) s_d.bst = (s_q.on_sel == 3'h0) ? fsc_pkg::ST_ON : fsc_pkg::ST_ONW;
      end
      fsc_pkg::ST_ONW: begin
        if (!above) s_d.bst = fsc_pkg::ST_OFF;
        else if (tick_i) begin
          s_d.btmr = s_q.btmr + 12'h1;
          if (s_d.btmr >= dly_sec(s_q.on_sel)) s_d.bst = fsc_pkg::ST_ON;
        end
      end
      fsc_pkg::ST_ON: begin
        s_d.btmr = 12'h0;
        if (below) s_d.bst = (s_q.off_sel == 3'h0) ? fsc_pkg::ST_OFF : fsc_pkg::ST_OFFW;
      end
      fsc_pkg::ST_OFFW: begin
        if (!below) s_d.bst = fsc_pkg::ST_ON;
        else if (tick_i) begin
          s_d.btmr = s_q.btmr + 12'h1;
          if (s_d.btmr >= dly_sec(s_q.off_sel)) s_d.bst = fsc_pkg::ST_OFF;
        end
      end
      default: s_d.bst = fsc_pkg::ST_OFF;
    endcase
    // Transmit: one telegram per cycle, clear before any new set
    s_d.txv = 1'b0;
    if (s_q.p_sun) begin
      s_d.p_sun = 1'b0;
      s_d.txv = 1'b1;
      s_d.kind = fsc_pkg::K_SUN;
      s_d.fac = 3'h0;
      s_d.txd = {azim_i, elev_i};
    end else begin
      for (int n = 0; n < 8; n++) begin
        if (!done && (s_q.p_shd[n] || s_q.p_hgt[n] || s_q.p_slat[n])) begin
          done = 1'b1;
          s_d.txv = 1'b1;
          s_d.fac = 3'(n);
          if (s_q.p_shd[n]) begin
            s_d.p_shd[n] = 1'b0;
            s_d.kind = fsc_pkg::K_SHADE;
            s_d.txd = s_q.fmtb ? {8'h0, s_q.shd[n] ? 8'hff : 8'h00}
                               : {15'h0, s_q.shd[n]};
            if (s_q.shd[n]) begin
              s_d.wrun[n] = 1'b1;
              s_d.wcnt[n] = 10'(s_q.wmin) * 10'(fsc_pkg::SEC_PER_MIN);
            end
          end else if (s_q.p_hgt[n]) begin
            s_d.p_hgt[n] = 1'b0;
            s_d.kind = fsc_pkg::K_HGT;
            s_d.txd = {9'h0, s_q.shd[n] ? s_q.hv[n] : 7'h0};
          end else begin
            s_d.p_slat[n] = 1'b0;
            s_d.kind = fsc_pkg::K_SLAT;
            // Tracked slat: closes as the sun sinks, plus offset
            tr = 8'(fsc_pkg::PCT_FULL) - 8'((elev_i > 7'h5a) ? 7'h5a : elev_i) + 8'(s_q.offs[n]);
            if (tr > 8'(fsc_pkg::PCT_FULL)) tr = 8'(fsc_pkg::PCT_FULL);
            if (tr < 8'(s_q.smin[n])) tr = 8'(s_q.smin[n]);
            if (tr > 8'(s_q.smax[n])) tr = 8'(s_q.smax[n]);
            s_d.txd = {9'h0, s_q.shd[n] ? tr[6:0] : s_q.smin[n]};
          end
        end
      end
    end
    // Facade shading changes and slat wait timers
    for (int n = 0; n < 8; n++) begin
      s_d.shd[n] = want[n];
      if (want[n] != s_q.shd[n]) begin
        s_d.p_shd[n] = 1'b1;
        s_d.wrun[n] = 1'b0;
        // Build on the next value so a telegram sent this cycle is not queued again
        if (want[n]) s_d.p_hgt[n] = s_d.p_hgt[n] | s_q.bbyte[n];
        else begin
          s_d.p_hgt[n] = s_d.p_hgt[n] | (s_q.hend & s_q.bbyte[n]);
          s_d.p_slat[n] = s_d.p_slat[n] | s_q.send;
        end
      end else if (s_q.wrun[n] && !s_q.p_shd[n]) begin
        if (s_q.wcnt[n] == 10'h0) begin
          s_d.wrun[n] = 1'b0;
          s_d.p_slat[n] = 1'b1;
        end else if (tick_i) s_d.wcnt[n] = s_q.wcnt[n] - 10'h1;
      end
    end
    // Cyclic shading resend
    if (s_q.cyc == 4'h0) s_d.cmin = 6'h0;
    else if (mtick) begin
      s_d.cmin = s_q.cmin + 6'h1;
      if (7'(s_d.cmin) >= 7'(s_q.cyc) * 7'(fsc_pkg::CYC_STEP_MIN)) begin
        s_d.cmin = 6'h0;
        for (int n = 0; n < 8; n++) begin
          if (4'(n) < s_q.nfac) s_d.p_shd[n] = 1'b1;
        end
      end
    end
    // Cyclic slat resend, in minutes
    if (s_q.slat_cyc == 8'h0) s_d.smcnt = 8'h0;
    else if (mtick) begin
      s_d.smcnt = s_q.smcnt + 8'h1;
      if (s_d.smcnt >= s_q.slat_cyc) begin
        s_d.smcnt = 8'h0;
        for (int n = 0; n < 8; n++) begin
          if (4'(n) < s_q.nfac) s_d.p_slat[n] = 1'b1;
        end
      end
    end
    // Slat resend on elevation step
    case (s_q.slat_step)
      3'h0:    stp = 7'h01;
      3'h1:    stp = 7'h03;
      3'h2:    stp = 7'h05;
      3'h3:    stp = 7'h0a;
      default: stp = 7'h0f;
    endcase
    if (el_diff(elev_i, s_q.el_slat) >= stp) begin
      s_d.el_slat = elev_i;
      for (int n = 0; n < 8; n++) begin
        if (4'(n) < s_q.nfac) s_d.p_slat[n] = 1'b1;
      end
    end
    // Sun position: cyclic in tens of seconds and on elevation step
    if (s_q.sun_cyc == 8'h0) s_d.suncnt = 12'h0;
    else if (tick_i) begin
      s_d.suncnt = s_q.suncnt + 12'h1;
      if (s_d.suncnt >= 12'(s_q.sun_cyc) * fsc_pkg::SUN_SEC_MULT) begin
        s_d.suncnt = 12'h0;
        s_d.p_sun = 1'b1;
      end
    end
    if (el_diff(elev_i, s_q.el_sun) >= (s_q.sun15 ? 7'h0f : 7'h0a)) begin
      s_d.el_sun = elev_i;
      s_d.p_sun = 1'b1;
    end
  end

  // State register, reset to defaults
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q <= '0;
      s_q.bst <= fsc_pkg::ST_OFF;
      s_q.nfac <= fsc_pkg::R_NFAC;
      s_q.klux <= fsc_pkg::R_KLUX;
      s_q.hyst <= fsc_pkg::R_HYST;
      s_q.hgt <= fsc_pkg::R_HGT;
      s_q.oint <= {8{fsc_pkg::R_OPEN}};
      s_q.smin <= {8{fsc_pkg::R_SMIN}};
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rd;
  assign tx_valid_o = s_q.txv;
  assign tx_kind_o = s_q.kind;
  assign tx_fac_o = s_q.fac;
  assign tx_data_o = s_q.txd;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence arm_s;
    s_q.bst == fsc_pkg::ST_OFF && above && s_q.on_sel != 3'h0;
  endsequence
  ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  ack_time_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  on_arm_a: assert property (arm_s |=> s_q.bst == fsc_pkg::ST_ONW) else $error("on delay not armed");
  on_now_a: assert property (s_q.bst == fsc_pkg::ST_OFF && above && s_q.on_sel == 3'h0
    |=> s_q.bst == fsc_pkg::ST_ON) else $error("no immediate on");
  on_drop_a: assert property (s_q.bst == fsc_pkg::ST_ONW && !above
    |=> s_q.bst == fsc_pkg::ST_OFF) else $error("on wait not cancelled");
  off_now_a: assert property (s_q.bst == fsc_pkg::ST_ON && below && s_q.off_sel == 3'h0
    |=> s_q.bst == fsc_pkg::ST_OFF) else $error("no immediate off");
  no_time_a: assert property (!time_valid_i |=> s_q.shd == 8'h0) else $error("shading without time");
  bit_fmt_a: assert property (tx_valid_o && tx_kind_o == fsc_pkg::K_SHADE && !$past(s_q.fmtb)
    |-> tx_data_o[15:1] == 15'h0) else $error("bad shading bit");
  zero_open_a: assert property ((sunlit & open0) == 8'h0) else $error("zero angle sunlit");
endmodule : fsc_ctrl

/* File: testbench/fsc_bus_model.sv */
`timescale 1ns/1ps
// Bus side stand-in: takes every telegram, keeps counts and the last shading value
module fsc_bus_model (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        tx_valid_i,
  input  wire logic [1:0]  tx_kind_i,
  input  wire logic [2:0]  tx_fac_i,
  input  wire logic [15:0] tx_data_i,
  output logic      [7:0]  n_shade_o,
  output logic      [7:0]  n_sun_o,
  output logic      [15:0] last_shade_o
);
  // Telegrams have no handshake, so the bus simply logs each shading and sun pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      n_shade_o    <= 8'h00;
      n_sun_o      <= 8'h00;
      last_shade_o <= 16'h0000;
    end else if (tx_valid_i) begin
      // Sun position telegrams carry facade 0 only
      if (tx_kind_i == fsc_pkg::K_SUN) begin
        n_sun_o <= n_sun_o + 8'h01;
      end
      // Shading value kept to judge the bit or byte format
      if (tx_kind_i == fsc_pkg::K_SHADE) begin
        n_shade_o    <= n_shade_o + 8'h01;
        last_shade_o <= tx_data_i;
      end
    end
  end
endmodule : fsc_bus_model

/* File: testbench/tb.sv */
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module tb;
  logic        clk_i = 1'b0;   // 10 MHz bench clock
  logic        rst_i = 1'b1;   // Synchronous reset
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o;
  logic        ack, tick = 1'b0, tvalid = 1'b1;
  logic [17:0] lux = 18'h0;
  logic [6:0]  elev = 7'h00;
  logic [8:0]  azim = 9'h000;  // Sun due north, inside the default opening
  logic        txv;
  logic [1:0]  txk;
  logic [2:0]  txf;
  logic [15:0] txd, last_shade;
  logic [7:0]  n_shade, n_sun, base;
  int          err_total = 0, comparisons = 0, cycles = 0;
  logic [7:0]  radr [6] = '{8'h00, 8'h04, 8'h10, 8'h40, 8'h44, 8'h20};
  logic [31:0] rexp [6] = '{32'h40, 32'h30a, 32'hfa, 32'h960000, 32'h32, 32'h0};

  always #50 clk_i = ~clk_i;

  fsc_ctrl fsc_ctrl_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .tick_i(tick), .time_valid_i(tvalid), .lux_i(lux), .elev_i(elev), .azim_i(azim),
    .tx_valid_o(txv), .tx_kind_o(txk), .tx_fac_o(txf), .tx_data_o(txd));
  fsc_bus_model fsc_bus_model_i (.clk_i(clk_i), .rst_i(rst_i), .tx_valid_i(txv), .tx_kind_i(txk),
    .tx_fac_i(txf), .tx_data_i(txd), .n_shade_o(n_shade), .n_sun_o(n_sun), .last_shade_o(last_shade));

  // Verdict and end of run, reached from the sequence or the watchdog
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  // Watchdog: the whole sequence needs well under this many cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles > 30000) begin
      err_total++;
      end_of_test();
    end
  end

  // One classic Wishbone cycle; request held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rdat = dat_o;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask : xfer

  // One-second time base pulses, one every four cycles
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk_i) tick <= 1'b1;
      @(posedge clk_i) tick <= 1'b0;
      repeat (2) @(posedge clk_i);
    end
    @(posedge clk_i);  // Lets the bus model's last count settle before a compare
  endtask : ticks

  // Status compare on decision state and facade shading bits only
  task automatic chk_st(input logic [7:0] l_unused, input logic [31:0] e);
    repeat (30) @(posedge clk_i);
    xfer(1'b0, 8'h14, 32'h0);
    `CHK("status", e, rdat & 32'h300ff)
  endtask : chk_st

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // Reset values, unmapped place reads zero
    for (int i = 0; i < 6; i++) begin
      xfer(1'b0, radr[i], 32'h0);
      `CHK("reset value", rexp[i], rdat)
    end
    xfer(1'b1, 8'h10, 32'h2290);
    xfer(1'b0, 8'h10, 32'h0);
    `CHK("height", 32'h2290, rdat)
    xfer(1'b1, 8'h14, 32'hffffffff);
    chk_st(0, 32'h0);
    // Threshold must be exceeded, not just met
    lux <= 18'd10000;
    chk_st(0, 32'h0);
    lux <= 18'd10001;
    chk_st(0, 32'h3000f);
    `CHK("shade count", 8'h04, n_shade)
    `CHK("shade bit", 16'h0001, last_shade)
    // Hysteresis: release level is 7000 lux
    lux <= 18'd7000;
    chk_st(0, 32'h3000f);
    lux <= 18'd6999;
    chk_st(0, 32'h0);
    // Byte format sends full scale when active
    xfer(1'b1, 8'h00, 32'h42);
    lux <= 18'd20000;
    chk_st(0, 32'h3000f);
    `CHK("shade byte", 16'h00ff, last_shade)
    lux <= 18'd0;
    // Bus threshold of 20 klux replaces the internal 10
    xfer(1'b1, 8'h00, 32'h41);
    xfer(1'b1, 8'h04, 32'h0014030a);
    lux <= 18'd15000;
    chk_st(0, 32'h0);
    lux <= 18'd20001;
    chk_st(0, 32'h3000f);
    // One facade; zero opening never shades
    xfer(1'b1, 8'h00, 32'h10);
    xfer(1'b1, 8'h40, 32'h0);
    chk_st(0, 32'h30000);
    // Half the 150 degree opening each side of the facade normal
    xfer(1'b1, 8'h40, 32'h0096004c);
    chk_st(0, 32'h30000);
    xfer(1'b1, 8'h40, 32'h0096004b);
    chk_st(0, 32'h30001);
    xfer(1'b1, 8'h40, 32'h00960000);
    chk_st(0, 32'h30001);
    // No valid time clears every shading output
    tvalid <= 1'b0;
    repeat (30) @(posedge clk_i);
    xfer(1'b0, 8'h14, 32'h0);
    `CHK("no time", 32'h0, rdat & 32'hff)
    tvalid <= 1'b1;
    lux <= 18'd0;
    chk_st(0, 32'h0);
    // One minute switch-on and switch-off delays
    xfer(1'b1, 8'h08, 32'h11);
    lux <= 18'd30000;
    ticks(55);
    chk_st(0, 32'h10000);
    ticks(10);
    chk_st(0, 32'h30001);
    lux <= 18'd0;
    ticks(55);
    chk_st(0, 32'h20001);
    ticks(10);
    chk_st(0, 32'h0);
    // Sun position every 10 s, then switched off by zero
    xfer(1'b1, 8'h0c, 32'h1);
    base = n_sun;
    ticks(30);
    `CHK("sun cyclic", 8'h03, n_sun - base)
    xfer(1'b1, 8'h0c, 32'h0);
    base = n_sun;
    ticks(30);
    `CHK("sun off", 8'h00, n_sun - base)
    // Elevation step of 10 degrees
    elev <= 7'd9;
    ticks(8);
    `CHK("sun step 9", 8'h00, n_sun - base)
    elev <= 7'd10;
    ticks(8);
    `CHK("sun step 10", 8'h01, n_sun - base)
    // Shading resent every 5 minutes: 300 ticks hold exactly five minute marks
    xfer(1'b1, 8'h08, 32'h100);
    base = n_shade;
    ticks(300);
    `CHK("shade cyclic", 8'h01, n_shade - base)
    end_of_test();
  end
endmodule : tb
